// File: hw/bus_control_unit.sv
/*
  Bus control unit: peripheral area decode with relocatable window, fetch
  guard, misaligned access splitter and external bus with mute state.
  Assumes the CPU holds one request at a time and the external memory
  controller answers each bus cycle with ext_ack_i.
*/
// What this block does
// - Fetches from peripheral area return no-operations
// - No prefetch from RAM top into peripherals
// - Byte, halfword, word accepted at any address
// - Odd halfword becomes two byte cycles
// - Odd word becomes byte, halfword, byte
// - Word at offset two becomes two halfwords
// - External bus muted whenever no access runs
// - Mute holds address, floats data, strobes high
// - Window base bit 15 enables the window
// - Window base bits 13..0 give address 27..14
// - Window decode ignores top four address bits
// - Window base is 16-bit, whole-unit, resets zero
// - Fixed registers also answer in window top
// - Overlapping window is ignored
module bus_control_unit (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic cpu_req_valid_i,
  input wire bcu_pkg::cpu_req_t cpu_req_i,
  output logic cpu_busy_o,
  output logic cpu_done_o,
  output logic cpu_nop_o,
  output logic [31:0] cpu_rdata_o,
  output logic window_active_o,
  input wire logic ext_ack_i,
  input wire logic [31:0] ext_data_i,
  output logic [22:0] ext_addr_o,
  output logic [31:0] ext_data_o,
  output logic ext_data_oe_o,
  output logic ext_rd_n_o,
  output logic ext_wr_n_o,
  output logic [3:0] ext_be_n_o,
  output logic [7:0] ext_cs_n_o
);

  function automatic logic [4:0] reg_index(input logic [11:0] a);
    logic [4:0] r;
    r = 5'h00;
    if (a == bcu_pkg::OFS_CSC_LO[11:0]) r = {1'b1, bcu_pkg::IDX_CSC_LO};
    else if (a == bcu_pkg::OFS_CSC_HI[11:0]) r = {1'b1, bcu_pkg::IDX_CSC_HI};
    else if (a == bcu_pkg::OFS_WIN[11:0]) r = {1'b1, bcu_pkg::IDX_WIN};
    else if (a == bcu_pkg::OFS_BEC[11:0]) r = {1'b1, bcu_pkg::IDX_BEC};
    else if (a == bcu_pkg::OFS_INTERNAL_PERIPH_WAIT_CTRL[11:0]) r = {1'b1, bcu_pkg::IDX_INTERNAL_PERIPH_WAIT_CTRL};
    else if (a == bcu_pkg::OFS_BCT_LO[11:0]) r = {1'b1, bcu_pkg::IDX_BCT_LO};
    else if (a == bcu_pkg::OFS_BCT_HI[11:0]) r = {1'b1, bcu_pkg::IDX_BCT_HI};
    else if (a == bcu_pkg::OFS_DWC_LO[11:0]) r = {1'b1, bcu_pkg::IDX_DWC_LO};
    else if (a == bcu_pkg::OFS_DWC_HI[11:0]) r = {1'b1, bcu_pkg::IDX_DWC_HI};
    else if (a == bcu_pkg::OFS_IDLE[11:0]) r = {1'b1, bcu_pkg::IDX_IDLE};
    else if (a == bcu_pkg::OFS_ASC[11:0]) r = {1'b1, bcu_pkg::IDX_ASC};
    else if (a == bcu_pkg::OFS_LBS[11:0]) r = {1'b1, bcu_pkg::IDX_LBS};
    else if (a == bcu_pkg::OFS_BMC[11:0]) r = {1'b1, bcu_pkg::IDX_BMC};
    else if (a == bcu_pkg::OFS_PRC[11:0]) r = {1'b1, bcu_pkg::IDX_PRC};
    else if (a == bcu_pkg::OFS_READ_STROBE_DELAY_CTRL[11:0]) r = {1'b1, bcu_pkg::IDX_READ_STROBE_DELAY_CTRL};
    return r;
  endfunction

  function automatic logic is_byte_reg(input logic [3:0] idx);
    return (idx == bcu_pkg::IDX_INTERNAL_PERIPH_WAIT_CTRL) || (idx == bcu_pkg::IDX_BMC) ||
      (idx == bcu_pkg::IDX_READ_STROBE_DELAY_CTRL);
  endfunction

  function automatic logic [1:0] part_count(input bcu_pkg::size_t s, input logic [1:0] a);
    logic [1:0] n;
    n = 2'h1;
    if (s == bcu_pkg::SZ_HALF && a[0]) n = 2'h2;
    else if (s == bcu_pkg::SZ_WORD && a[0]) n = 2'h3;
    else if (s == bcu_pkg::SZ_WORD && a[1]) n = 2'h2;
    return n;
  endfunction

  // Length and byte offset of part k, in ascending address order
  function automatic bcu_pkg::part_t part_of(input bcu_pkg::size_t s, input logic [1:0] a,
                                             input logic [1:0] k);
    bcu_pkg::part_t p;
    p.len = 3'h1;
    p.off = 2'h0;
    case (s)
      bcu_pkg::SZ_HALF:
      begin
        if (a[0])
        begin
          p.off = k;
        end
        else
        begin
          p.len = 3'h2;
        end
      end
      bcu_pkg::SZ_WORD:
      begin
        if (a[0])
        begin
          p.len = (k == 2'h1) ? 3'h2 : 3'h1;
          p.off = (k == 2'h0) ? 2'h0 : ((k == 2'h1) ? 2'h1 : 2'h3);
        end
        else if (a[1])
        begin
          p.len = 3'h2;
          p.off = k[0] ? 2'h2 : 2'h0;
        end
        else
        begin
          p.len = 3'h4;
        end
      end
      default:
      begin
        p.len = 3'h1;
      end
    endcase
    return p;
  endfunction

  function automatic logic in_fixed(input logic [31:0] a);
    return a[25:12] == bcu_pkg::FIXED_SEL;
  endfunction

  function automatic logic in_ram(input logic [31:0] a);
    return (a[25:0] >= bcu_pkg::RAM_BASE) && (a[25:0] <= bcu_pkg::RAM_END);
  endfunction

  // One-hot chip select with fixed priority inside each group of four
  function automatic logic [7:0] cs_select(input logic [2:0] bank, input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [7:0] cs;
    cs = 8'h00;
    if (!bank[2])
    begin
      if (lo[{2'h0, bank[1:0]}]) cs[0] = 1'b1;
      else if (lo[{2'h2, bank[1:0]}]) cs[2] = 1'b1;
      else if (lo[{2'h1, bank[1:0]}]) cs[1] = 1'b1;
      else if (lo[{2'h3, bank[1:0]}]) cs[3] = 1'b1;
    end
    else
    begin
      if (hi[{2'h0, bank[1:0]}]) cs[7] = 1'b1;
      else if (hi[{2'h2, bank[1:0]}]) cs[5] = 1'b1;
      else if (hi[{2'h1, bank[1:0]}]) cs[6] = 1'b1;
      else if (hi[{2'h3, bank[1:0]}]) cs[4] = 1'b1;
    end
    return cs;
  endfunction

  bcu_pkg::state_t state_q, state_d;
  bcu_pkg::cpu_req_t req_q;
  logic [1:0] part_q;
  logic [1:0] nparts_q;
  logic [31:0] acc_q;
  logic [3:0] idx_q;
  logic idx_ok_q;
  logic [bcu_pkg::N_REGS-1:0][15:0] words;
  logic [15:0] reg_rdata;

  // Window decode
  wire logic [15:0] win_reg = words[bcu_pkg::IDX_WIN];
  wire logic [13:0] win_base = win_reg[13:0];
  wire logic [25:0] win_lo = {win_base[11:0], 14'h0000};
  wire logic [25:0] win_hi = {win_base[11:0], 14'h3FFF};
  wire logic win_overlap = (win_base[11:0] == bcu_pkg::FIXED_SEL[13:2]) ||
    (win_lo <= bcu_pkg::ROM_END) ||
    ((win_hi >= bcu_pkg::RAM_BASE) && (win_lo <= bcu_pkg::RAM_END));
  wire logic win_ok = win_reg[bcu_pkg::WIN_EN_BIT] && !win_overlap;

  // Request classification; bits 31..28 take no part in the window match
  wire logic [31:0] a_cur = cpu_req_i.addr;
  wire logic [31:0] a_last = cpu_req_i.addr + 32'h00000003;
  wire logic hit_win = win_ok && (a_cur[27:14] == win_base);
  wire logic hit_win_last = win_ok && (a_last[27:14] == win_base);
  wire logic is_periph = in_fixed(a_cur) || hit_win;
  wire logic reg_space = in_fixed(a_cur) || (hit_win && a_cur[13]);
  wire logic crosses = in_ram(a_cur) && (in_fixed(a_last) || hit_win_last);
  wire logic fetch_block = cpu_req_i.fetch && (is_periph || crosses);
  wire logic take = (state_q == bcu_pkg::ST_IDLE) && cpu_req_valid_i;
  wire logic take_ext = take && !fetch_block && !is_periph;

  wire logic [4:0] ridx = reg_index(a_cur[11:0]);
  wire logic size_ok = is_byte_reg(ridx[3:0]) ? (cpu_req_i.size == bcu_pkg::SZ_BYTE) :
    ((cpu_req_i.size == bcu_pkg::SZ_HALF) && !a_cur[0]);
  wire logic reg_ok = reg_space && ridx[4] && size_ok;

  // Bus cycle to issue now, either the first part or the next one
  wire logic issue = take_ext || (state_q == bcu_pkg::ST_GAP);
  wire bcu_pkg::cpu_req_t src = (state_q == bcu_pkg::ST_IDLE) ? cpu_req_i : req_q;
  wire logic [1:0] kidx = (state_q == bcu_pkg::ST_IDLE) ? 2'h0 : part_q;
  wire bcu_pkg::part_t pinfo = part_of(src.size, src.addr[1:0], kidx);
  wire logic [31:0] paddr = src.addr + {30'h0, pinfo.off};
  wire logic [7:0] cs_hit = cs_select(paddr[25:23], words[bcu_pkg::IDX_CSC_LO],
    words[bcu_pkg::IDX_CSC_HI]);

  // Part currently on the bus, used to merge read data
  wire bcu_pkg::part_t cinfo = part_of(req_q.size, req_q.addr[1:0], part_q);
  wire logic [1:0] clane = req_q.addr[1:0] + cinfo.off;
  wire logic last = (part_q == (nparts_q - 2'h1));
  wire logic ack_now = (state_q == bcu_pkg::ST_EXT) && ext_ack_i;

  logic [3:0] be;
  logic [31:0] wlanes;
  logic [31:0] merged;

  // Little-endian lane steering: byte j of the CPU word sits at address addr+j
  for (genvar l = 0; l < 4; l++)
  begin : g_lane
    wire logic [1:0] rel_w = 2'(l) - paddr[1:0];
    wire logic [1:0] rel_r = 2'(l) - cinfo.off;
    wire logic [1:0] src_lane = rel_r + clane;
    assign be[l] = {1'b0, rel_w} < pinfo.len;
    // Wrap the byte index so that disabled lanes never select past the word
    assign wlanes[8*l +: 8] = src.wdata[8*2'(rel_w + pinfo.off) +: 8];
    assign merged[8*l +: 8] = ({1'b0, rel_r} < cinfo.len) ?
      ext_data_i[8*src_lane +: 8] : acc_q[8*l +: 8];
  end

  wire logic [15:0] reg_wdata = (req_q.wdata[15:0] &
    (is_byte_reg(idx_q) ? bcu_pkg::BYTE_REG_MASK : 16'hFFFF)) &
    ((idx_q == bcu_pkg::IDX_WIN) ? bcu_pkg::WIN_WRITE_MASK : 16'hFFFF);
  wire logic reg_we = (state_q == bcu_pkg::ST_REG) && req_q.write && idx_ok_q;

  reg_store u_reg_store (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .we_i(reg_we),
    .widx_i(idx_q),
    .wdata_i(reg_wdata),
    .ridx_i(idx_q),
    .rdata_o(reg_rdata),
    .words_o(words)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      bcu_pkg::ST_IDLE:
      begin
        if (take && !fetch_block)
        begin
          state_d = is_periph ? bcu_pkg::ST_REG : bcu_pkg::ST_EXT;
        end
      end
      bcu_pkg::ST_REG:
      begin
        state_d = bcu_pkg::ST_RRESP;
      end
      bcu_pkg::ST_RRESP:
      begin
        state_d = bcu_pkg::ST_IDLE;
      end
      bcu_pkg::ST_EXT:
      begin
        if (ext_ack_i)
        begin
          state_d = last ? bcu_pkg::ST_IDLE : bcu_pkg::ST_GAP;
        end
      end
      bcu_pkg::ST_GAP:
      begin
        state_d = bcu_pkg::ST_EXT;
      end
      default:
      begin
        state_d = bcu_pkg::ST_IDLE;
      end
    endcase
  end

  wire logic done_d = (take && fetch_block) || (state_q == bcu_pkg::ST_RRESP) ||
    (ack_now && last);
  wire logic [31:0] rdata_d = (take && fetch_block) ? bcu_pkg::NOP_WORD :
    (state_q == bcu_pkg::ST_RRESP) ?
    ((idx_ok_q && !req_q.write) ? {16'h0000, reg_rdata} : 32'h00000000) :
    (ack_now && last && !req_q.write) ? merged : cpu_rdata_o;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= bcu_pkg::ST_IDLE;
      req_q <= '0;
      nparts_q <= 2'h1;
      idx_q <= 4'h0;
      idx_ok_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (take)
      begin
        req_q <= cpu_req_i;
        nparts_q <= part_count(cpu_req_i.size, a_cur[1:0]);
        idx_q <= ridx[3:0];
        idx_ok_q <= reg_ok;
      end
    end
  end

  // Part counter and read accumulator
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      part_q <= 2'h0;
      acc_q <= 32'h00000000;
    end
    else if (take)
    begin
      part_q <= 2'h0;
      acc_q <= 32'h00000000;
    end
    else if (ack_now)
    begin
      part_q <= part_q + 2'h1;
      acc_q <= merged;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cpu_busy_o <= 1'b0;
      cpu_done_o <= 1'b0;
      cpu_nop_o <= 1'b0;
      cpu_rdata_o <= 32'h00000000;
      window_active_o <= 1'b0;
    end
    else
    begin
      cpu_busy_o <= state_d != bcu_pkg::ST_IDLE;
      cpu_done_o <= done_d;
      cpu_nop_o <= take && fetch_block;
      cpu_rdata_o <= rdata_d;
      window_active_o <= win_ok;
    end
  end

  // External pins; the address is only ever loaded on issue, so it holds
  // the last external address throughout the mute state
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ext_addr_o <= 23'h000000;
      ext_data_o <= 32'h00000000;
    end
    else if (issue)
    begin
      ext_addr_o <= paddr[22:0];
      ext_data_o <= wlanes;
    end
  end

  // Strobes leave the mute levels only while a part is on the bus
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ext_data_oe_o <= 1'b0;
      ext_rd_n_o <= 1'b1;
      ext_wr_n_o <= 1'b1;
      ext_be_n_o <= 4'hF;
      ext_cs_n_o <= 8'hFF;
    end
    else if (issue)
    begin
      ext_data_oe_o <= src.write;
      ext_rd_n_o <= src.write;
      ext_wr_n_o <= !src.write;
      ext_be_n_o <= ~be;
      ext_cs_n_o <= ~cs_hit;
    end
    else if (ack_now)
    begin
      ext_data_oe_o <= 1'b0;
      ext_rd_n_o <= 1'b1;
      ext_wr_n_o <= 1'b1;
      ext_be_n_o <= 4'hF;
      ext_cs_n_o <= 8'hFF;
    end
  end

endmodule

// File: hw/bcu_pkg.sv
/*
  Constants, register map and types of the bus control unit.
  Assumes a 32-bit CPU address space in which bits 31..26 are ignored by the
  fixed peripheral decode and bits 31..28 by the window decode, and one system
  clock shared by all users.
*/
package bcu_pkg;

  localparam int N_REGS = 16;

  // Register addresses as the CPU sees them; only bits 11..0 are decoded
  localparam logic [31:0] OFS_CSC_LO = 32'hFFFFF060;
  localparam logic [31:0] OFS_CSC_HI = 32'hFFFFF062;
  localparam logic [31:0] OFS_WIN = 32'hFFFFF064;
  localparam logic [31:0] OFS_BEC = 32'hFFFFF068;
  localparam logic [31:0] OFS_INTERNAL_PERIPH_WAIT_CTRL = 32'hFFFFF06E;
  localparam logic [31:0] OFS_BCT_LO = 32'hFFFFF480;
  localparam logic [31:0] OFS_BCT_HI = 32'hFFFFF482;
  localparam logic [31:0] OFS_DWC_LO = 32'hFFFFF484;
  localparam logic [31:0] OFS_DWC_HI = 32'hFFFFF486;
  localparam logic [31:0] OFS_IDLE = 32'hFFFFF488;
  localparam logic [31:0] OFS_ASC = 32'hFFFFF48A;
  localparam logic [31:0] OFS_LBS = 32'hFFFFF48E;
  localparam logic [31:0] OFS_BMC = 32'hFFFFF498;
  localparam logic [31:0] OFS_PRC = 32'hFFFFF49A;
  localparam logic [31:0] OFS_READ_STROBE_DELAY_CTRL = 32'hFFFFFF00;

  // Storage slots inside the register store
  localparam logic [3:0] IDX_CSC_LO = 4'h0;
  localparam logic [3:0] IDX_CSC_HI = 4'h1;
  localparam logic [3:0] IDX_WIN = 4'h2;
  localparam logic [3:0] IDX_BEC = 4'h3;
  localparam logic [3:0] IDX_INTERNAL_PERIPH_WAIT_CTRL = 4'h4;
  localparam logic [3:0] IDX_BCT_LO = 4'h5;
  localparam logic [3:0] IDX_BCT_HI = 4'h6;
  localparam logic [3:0] IDX_DWC_LO = 4'h7;
  localparam logic [3:0] IDX_DWC_HI = 4'h8;
  localparam logic [3:0] IDX_IDLE = 4'h9;
  localparam logic [3:0] IDX_ASC = 4'hA;
  localparam logic [3:0] IDX_LBS = 4'hB;
  localparam logic [3:0] IDX_BMC = 4'hC;
  localparam logic [3:0] IDX_PRC = 4'hD;
  localparam logic [3:0] IDX_READ_STROBE_DELAY_CTRL = 4'hE;

  localparam logic [15:0] RST_CSC = 16'h2C11;
  localparam logic [15:0] RST_WIN = 16'h0000;
  localparam logic [15:0] RST_INTERNAL_PERIPH_WAIT_CTRL = 16'h0077;
  localparam logic [15:0] RST_OTHER = 16'h0000;
  localparam logic [15:0] RESET_VALS [N_REGS] = '{RST_CSC, RST_CSC, RST_WIN, RST_OTHER,
    RST_INTERNAL_PERIPH_WAIT_CTRL, RST_OTHER, RST_OTHER, RST_OTHER, RST_OTHER, RST_OTHER, RST_OTHER,
    RST_OTHER, RST_OTHER, RST_OTHER, RST_OTHER, RST_OTHER};

  // Window base register fields
  localparam int WIN_EN_BIT = 15;
  localparam int WIN_RSVD_BIT = 14;
  localparam logic [15:0] WIN_WRITE_MASK = 16'hBFFF;
  localparam logic [15:0] BYTE_REG_MASK = 16'h00FF;

  // Address map inside one 64 MB mirror (bits 25..0)
  localparam logic [13:0] FIXED_SEL = 14'h3FFF;
  localparam logic [25:0] ROM_END = 26'h00FFFFF;
  localparam logic [25:0] RAM_BASE = 26'h3FF0000;
  localparam logic [25:0] RAM_END = 26'h3FFEFFF;

  // Word returned for a refused instruction fetch
  localparam logic [31:0] NOP_WORD = 32'h00000000;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } size_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_REG = 3'b001,
    ST_RRESP = 3'b010,
    ST_EXT = 3'b011,
    ST_GAP = 3'b100
  } state_t;

  typedef struct packed {
    logic fetch;
    logic write;
    size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic [2:0] len;
    logic [1:0] off;
  } part_t;

endpackage

// File: hw/reg_store.sv
/*
  Register store of the bus control unit: sixteen 16-bit words with reset
  values, one write port and a registered read port.
  Assumes the caller has already checked access width and address.
*/
module reg_store (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic we_i,
  input wire logic [3:0] widx_i,
  input wire logic [15:0] wdata_i,
  input wire logic [3:0] ridx_i,
  output logic [15:0] rdata_o,
  output logic [bcu_pkg::N_REGS-1:0][15:0] words_o
);

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < bcu_pkg::N_REGS; i++)
      begin
        words_o[i] <= bcu_pkg::RESET_VALS[i];
      end
    end
    else if (we_i)
    begin
      words_o[widx_i] <= wdata_i;
    end
  end

  // Read sees the value before a write in the same cycle
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= 16'h0000;
    end
    else
    begin
      rdata_o <= words_o[ridx_i];
    end
  end

endmodule

// File: dv/bus_control_unit_properties.sv
/*
  Port checker of the bus control unit: fetch guard, register latency, mute.
  Assumes it is bound to bus_control_unit and sees only its ports.
*/
module bus_control_unit_properties (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic cpu_req_valid_i,
  input wire bcu_pkg::cpu_req_t cpu_req_i,
  input wire logic cpu_busy_o,
  input wire logic cpu_done_o,
  input wire logic cpu_nop_o,
  input wire logic [31:0] cpu_rdata_o,
  input wire logic ext_ack_i,
  input wire logic [22:0] ext_addr_o,
  input wire logic ext_data_oe_o,
  input wire logic ext_rd_n_o,
  input wire logic ext_wr_n_o,
  input wire logic [3:0] ext_be_n_o,
  input wire logic [7:0] ext_cs_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  wire logic strobe_on = !ext_rd_n_o || !ext_wr_n_o;
  wire logic in_fixed = cpu_req_i.addr[25:12] == 14'h3FFF;
  wire logic ram_top = cpu_req_i.addr[25:0] > 26'h3FFEFFC && cpu_req_i.addr[25:0] < 26'h3FFF000;

  sequence s_take;
    cpu_req_valid_i && !cpu_busy_o;
  endsequence
  sequence s_take_fetch;
    s_take ##0 cpu_req_i.fetch;
  endsequence

  a_fetch_fixed_nop: assert property (s_take_fetch ##0 in_fixed |=> cpu_done_o && cpu_nop_o)
    else $error("fetch from peripheral area not refused");
  a_ram_top_fetch: assert property (s_take_fetch ##0 ram_top |=> cpu_nop_o && !strobe_on)
    else $error("prefetch crossed into peripheral area");
  a_nop_word: assert property (cpu_nop_o |-> cpu_done_o && cpu_rdata_o == bcu_pkg::NOP_WORD)
    else $error("refused fetch without no-operation word");
  a_reg_done_latency: assert property (s_take ##0 (in_fixed && !cpu_req_i.fetch)
    |-> ##3 cpu_done_o)
    else $error("register access did not finish in three cycles");
  a_busy_ends_done: assert property ($fell(cpu_busy_o) |-> cpu_done_o)
    else $error("request dropped without completion");
  a_mute_when_idle: assert property (!cpu_busy_o |-> !strobe_on && ext_cs_n_o == 8'hFF
    && ext_be_n_o == 4'hF && !ext_data_oe_o)
    else $error("external bus not muted while idle");
  a_addr_hold: assert property (!$stable(ext_addr_o) |-> strobe_on)
    else $error("address moved outside a bus cycle");
  a_data_float: assert property (ext_data_oe_o |-> !ext_wr_n_o)
    else $error("data driven outside a write cycle");
  a_release_after_ack: assert property (strobe_on && ext_ack_i |=> !strobe_on [*1]
    ##0 ext_cs_n_o == 8'hFF)
    else $error("strobes not released after acknowledge");
  a_lane_enable: assert property (strobe_on |-> !ext_be_n_o[ext_addr_o[1:0]])
    else $error("first lane does not match address");
endmodule

bind bus_control_unit bus_control_unit_properties u_props (.clk_sys_i(clk_sys_i),
  .arst_n_i(arst_n_i), .cpu_req_valid_i(cpu_req_valid_i), .cpu_req_i(cpu_req_i),
  .cpu_busy_o(cpu_busy_o), .cpu_done_o(cpu_done_o), .cpu_nop_o(cpu_nop_o),
  .cpu_rdata_o(cpu_rdata_o), .ext_ack_i(ext_ack_i), .ext_addr_o(ext_addr_o),
  .ext_data_oe_o(ext_data_oe_o), .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o),
  .ext_be_n_o(ext_be_n_o), .ext_cs_n_o(ext_cs_n_o));

// File: dv/ext_mem_model.sv
/*
  External memory on the chip-select bus: 256 bytes, prompt or slow acknowledge.
  Assumes byte addresses with lane l at address low bits l.
*/
module ext_mem_model (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic slow_i,
  input wire logic [22:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [3:0] be_n_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  logic [1:0] wait_q;
  logic [31:0] last_q;
  wire logic active = !rd_n_i || !wr_n_i;
  assign ack_o = active && wait_q == (slow_i ? 2'h2 : 2'h0);
  // A released bus shows the inverse of its previous-cycle value, so it alternates between the inverse and the last read data
  assign rdata_o = rd_n_i ? ~last_q : {mem[{addr_i[7:2], 2'h3}], mem[{addr_i[7:2], 2'h2}],
    mem[{addr_i[7:2], 2'h1}], mem[{addr_i[7:2], 2'h0}]};
  initial
  begin
    foreach (mem[i]) mem[i] = 8'(i);
  end
  always @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wait_q <= 2'h0;
      last_q <= 32'h0;
    end
    else
    begin
      wait_q <= (active && !ack_o) ? wait_q + 2'h1 : 2'h0;
      last_q <= rdata_o;
      for (int l = 0; l < 4; l++)
        if (!wr_n_i && ack_o && !be_n_i[l])
          mem[{addr_i[7:2], 2'(l)}] <= wdata_i[8*l +: 8];
    end
  end
endmodule

// File: dv/test_bus_control_unit.sv
/*
  Testbench of the bus control unit: registers, fetch guard, window, splitting.
  Assumes the CPU request port is the only register path.
*/
module test_bus_control_unit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [22:0] addr; logic [3:0] be_n; logic [7:0] cs_n;} part_seen_t;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cpu_req_valid_i = 1'b0;
  bcu_pkg::cpu_req_t cpu_req_i = '0;
  logic slow = 1'b0;
  logic cpu_busy_o, cpu_done_o, cpu_nop_o, window_active_o, ext_ack_i, ext_data_oe_o;
  logic ext_rd_n_o, ext_wr_n_o, nop, act_q;
  logic [31:0] cpu_rdata_o, ext_data_i, ext_data_o, rd, wd, msk;
  logic [22:0] ext_addr_o;
  logic [3:0] ext_be_n_o;
  logic [7:0] ext_cs_n_o;
  int fail_count = 0;
  int checked = 0;
  int nb;
  part_seen_t parts[$];
  bcu_pkg::size_t sz_tab [5] = '{bcu_pkg::SZ_WORD, bcu_pkg::SZ_HALF, bcu_pkg::SZ_WORD,
    bcu_pkg::SZ_WORD, bcu_pkg::SZ_BYTE};
  logic [31:0] adr_tab [5] = '{32'h101, 32'h107, 32'h10A, 32'h110, 32'h115};
  int np_tab [5] = '{3, 2, 2, 1, 1};

  always #5 clk_sys_i = ~clk_sys_i;

  bus_control_unit DUT (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .cpu_req_valid_i(cpu_req_valid_i), .cpu_req_i(cpu_req_i), .cpu_busy_o(cpu_busy_o),
    .cpu_done_o(cpu_done_o), .cpu_nop_o(cpu_nop_o), .cpu_rdata_o(cpu_rdata_o),
    .window_active_o(window_active_o), .ext_ack_i(ext_ack_i), .ext_data_i(ext_data_i),
    .ext_addr_o(ext_addr_o), .ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o),
    .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o), .ext_be_n_o(ext_be_n_o),
    .ext_cs_n_o(ext_cs_n_o));

  ext_mem_model u_mem (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .slow_i(slow),
    .addr_i(ext_addr_o), .wdata_i(ext_data_o), .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o),
    .be_n_i(ext_be_n_o), .ack_o(ext_ack_i), .rdata_o(ext_data_i));

  // Each falling strobe starts one bus cycle
  always @(posedge clk_sys_i)
  begin
    if ((!ext_rd_n_o || !ext_wr_n_o) && !act_q)
      parts.push_back({ext_addr_o, ext_be_n_o, ext_cs_n_o});
    act_q <= !ext_rd_n_o || !ext_wr_n_o;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Called at a falling edge; returns one falling edge after completion
  task automatic access(input logic f, input logic w, input bcu_pkg::size_t sz,
    input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    parts.delete();
    cpu_req_i = '{fetch: f, write: w, size: sz, addr: a, wdata: d};
    cpu_req_valid_i = 1'b1;
    @(negedge clk_sys_i);
    cpu_req_valid_i = 1'b0;
    while (cpu_done_o !== 1'b1 && n < 60)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n == 60)
    begin
      fail_count++;
      conclude();
    end
    rd = cpu_rdata_o;
    nop = cpu_nop_o;
    @(negedge clk_sys_i);
  endtask

  task automatic split_check(input logic [31:0] a, input int bytes, input int np);
    logic [22:0] nxt;
    int sum;
    nxt = a[22:0];
    sum = 0;
    check(32'(parts.size()), 32'(np));
    foreach (parts[k])
    begin
      check(32'(parts[k].addr), 32'(nxt));
      check(32'(parts[k].cs_n), 32'hFE);
      nxt = nxt + 23'(4 - $countones(parts[k].be_n));
      sum = sum + 4 - $countones(parts[k].be_n);
    end
    check(32'(sum), 32'(bytes));
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    access(0, 0, bcu_pkg::SZ_HALF, bcu_pkg::OFS_WIN, 0);
    check(rd, 32'h0);
    check(32'(window_active_o), 32'h0);
    access(0, 0, bcu_pkg::SZ_HALF, bcu_pkg::OFS_CSC_LO, 0);
    check(rd, 32'h2C11);
    // A halfword write to a byte register must be ignored
    access(0, 1, bcu_pkg::SZ_HALF, bcu_pkg::OFS_INTERNAL_PERIPH_WAIT_CTRL, 32'h0011);
    access(0, 0, bcu_pkg::SZ_BYTE, bcu_pkg::OFS_INTERNAL_PERIPH_WAIT_CTRL, 0);
    check(rd, 32'h77);
    access(0, 0, bcu_pkg::SZ_HALF, 32'hFFFFF0F0, 0);
    check(rd, 32'h0);
    access(0, 1, bcu_pkg::SZ_HALF, bcu_pkg::OFS_WIN, 32'hFFFF);
    access(0, 0, bcu_pkg::SZ_HALF, bcu_pkg::OFS_WIN, 0);
    check(rd, 32'hBFFF);
    check(32'(window_active_o), 32'h0);
    access(0, 1, bcu_pkg::SZ_HALF, bcu_pkg::OFS_WIN, 32'h8FFB);
    check(32'(window_active_o), 32'h1);
    access(0, 0, bcu_pkg::SZ_HALF, 32'hF3FEE064, 0);
    check(rd, 32'h8FFB);
    access(0, 0, bcu_pkg::SZ_HALF, 32'h03FEC064, 0);
    check(rd, 32'h0);
    access(1, 0, bcu_pkg::SZ_WORD, 32'h03FEC000, 0);
    check(32'(nop), 32'h1);
    access(1, 0, bcu_pkg::SZ_WORD, 32'hFFFFF000, 0);
    check(32'(nop), 32'h1);
    access(1, 0, bcu_pkg::SZ_WORD, 32'h03FFEFFD, 0);
    check(32'(nop), 32'h1);
    access(0, 1, bcu_pkg::SZ_HALF, bcu_pkg::OFS_WIN, 32'h0FFB);
    check(32'(window_active_o), 32'h0);
    // Only bank 0 is populated, so other banks lose their selects
    access(0, 1, bcu_pkg::SZ_HALF, bcu_pkg::OFS_CSC_LO, 32'h0001);
    access(0, 1, bcu_pkg::SZ_HALF, bcu_pkg::OFS_CSC_HI, 32'h0000);
    access(1, 0, bcu_pkg::SZ_WORD, 32'h03FFEFFC, 0);
    check(32'(nop), 32'h0);
    for (int s = 0; s < 2; s++)
    begin
      slow = s[0];
      for (int k = 0; k < 5; k++)
      begin
        nb = 1 << sz_tab[k];
        msk = (nb == 4) ? 32'hFFFFFFFF : (32'h1 << (8 * nb)) - 32'h1;
        wd = 32'hA4B3C2D1 ^ 32'(k + 16 * s);
        access(0, 1, sz_tab[k], adr_tab[k], wd);
        split_check(adr_tab[k], nb, np_tab[k]);
        access(0, 0, sz_tab[k], adr_tab[k], 0);
        split_check(adr_tab[k], nb, np_tab[k]);
        check(rd, wd & msk);
      end
    end
    conclude();
  end
endmodule
